/* File: verilog/stw_map.svh */
// Purpose: Offsets, field positions and reset values of the two-wire channel
// Assumes: 32-bit classic Wishbone, one register per aligned word
// Notes: Definitions only
`ifndef STW_MAP_SVH
`define STW_MAP_SVH

// ==========================================================================
// Register byte offsets
`define STW_OFS_MODE 8'h00
`define STW_OFS_COMM 8'h04
`define STW_OFS_DATA 8'h08
`define STW_OFS_OLAT 8'h0c
`define STW_OFS_OEN 8'h10
`define STW_OFS_START 8'h14
`define STW_OFS_STOP 8'h18
`define STW_OFS_STAT 8'h1c
`define STW_OFS_CLR 8'h20
`define STW_OFS_PRS 8'h24

// ==========================================================================
// Field positions
`define STW_MODE_PRS_SEL 15
`define STW_DIV_MSB 15
`define STW_DIV_LSB 9
`define STW_OLAT_CLK 8
`define STW_OLAT_DATA 0
`define STW_OEN_CH 0
`define STW_TRIG_CH 0
`define STW_STAT_OVR 0
`define STW_STAT_BFF 5
`define STW_STAT_BUSY 6
`define STW_PRS0_LSB 0
`define STW_PRS1_LSB 4

// ==========================================================================
// Reset values and codes
`define STW_RST_MODE 16'h0020
`define STW_RST_COMM 16'h0087
`define STW_RST_DATA 16'h0200
`define STW_RST_OLAT 16'h0f0f
`define STW_RST_OEN 16'h0000
`define STW_RST_PRS 16'h0000
`define STW_PRS_MAX 4'hb
`define STW_PRS_TIMER 4'hf
`define STW_BITS_PER_FRAME 4'h8

`endif

/* File: verilog/stw_pkg.sv */
// Purpose: Types shared by the two-wire receive channel
// Assumes: Nothing
// Notes: Constants live in stw_map.svh
`default_nettype none
package stw_pkg;
	typedef enum logic [1:0] {
		STW_IDLE,
		STW_LOW,
		STW_HIGH
	} stw_state_t;

	typedef logic [3:0] stw_prs_code_t;
endpackage
`default_nettype wire

/* File: verilog/stw_sync.sv */
// Purpose: Two-flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk_i
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module stw_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Data
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= INIT;
			q_o <= INIT;
		end else if (ce_i) begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule
`default_nettype wire

/* File: verilog/stw_prescaler.sv */
// Purpose: Operation-clock tick from the system clock
// Assumes: timer_tick_i is a one-cycle pulse on clk_i
// Notes: Codes 12 to 14 give no tick at all; code 15 passes timer_tick_i
`timescale 1ns/1ns
`default_nettype none
`include "stw_map.svh"
module stw_prescaler #(
	parameter int CNT_W = 11
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Selection
	input wire stw_pkg::stw_prs_code_t code_i,
	input wire logic timer_tick_i,
	// Tick
	output logic tick_o
);
	import stw_pkg::*;

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] mask;

	always_comb begin
		mask = '0;
		for (int i = 0; i < CNT_W; i++) begin
			if (i < int'(code_i)) begin
				mask[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= '0;
		end else if (ce_i) begin
			cnt <= cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_o <= 1'b0;
		end else if (ce_i) begin
			if (code_i <= `STW_PRS_MAX) begin
				tick_o <= ((cnt & mask) == mask);
			end else if (code_i == `STW_PRS_TIMER) begin
				tick_o <= timer_tick_i;
			end else begin
				tick_o <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* File: verilog/stw_rx_channel.sv */
// Purpose: Master-only two-wire channel, data reception and acknowledge slot
// Assumes: Open-drain pads outside; oe high pulls the wire low
// Notes: Each write to the data register while idle and enabled receives one byte
`timescale 1ns/1ns
`default_nettype none
`include "stw_map.svh"
module stw_rx_channel #(
	parameter int DIV_W = 7
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Operation clock source
	input wire logic timer_tick_i,
	// Two-wire pins
	input wire logic two_wire_data_pin_i,
	output logic two_wire_clock_pin_o,
	output logic two_wire_clock_pin_oe_o,
	output logic two_wire_data_pin_o,
	output logic two_wire_data_pin_oe_o,
	// Events
	output logic transfer_end_irq_o
);
	import stw_pkg::*;
	default clocking stw_cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// ======================================================================
	// Declarations
	stw_state_t state;
	logic [15:0] channel_mode_reg, channel_comm_setting_reg;
	logic [15:0] serial_output_latch_reg, serial_output_enable_reg;
	logic [15:0] prescaler_select_reg;
	logic [DIV_W-1:0] divider, ph_cnt;
	logic [7:0] received_byte_field, shift;
	logic [3:0] bit_cnt;
	logic enabled, buffer_full_flag, overrun_flag;
	logic sda_s, op_tick, half_done, byte_done;
	logic wb_acc, wb_wr, rd_data, next_scl_oe, next_sda_oe;
	logic wr_mode, wr_comm, wr_data, wr_olat, wr_oen;
	logic wr_start, wr_stop, wr_clr, wr_prs;
	stw_prs_code_t prs_code;
	logic [31:0] next_rdata;

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		merge = old;
		if (sel[0]) begin
			merge[7:0] = nw[7:0];
		end
		if (sel[1]) begin
			merge[15:8] = nw[15:8];
		end
	endfunction

	// ======================================================================
	// Submodules
	stw_sync #(.WIDTH(1), .INIT(1'b1)) stw_sync_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.d_i(two_wire_data_pin_i),
		.q_o(sda_s)
	);
	assign prs_code = channel_mode_reg[`STW_MODE_PRS_SEL] ?
		prescaler_select_reg[`STW_PRS1_LSB +: 4] :
		prescaler_select_reg[`STW_PRS0_LSB +: 4];
	stw_prescaler #(.CNT_W(11)) stw_prescaler_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.code_i(prs_code),
		.timer_tick_i(timer_tick_i),
		.tick_o(op_tick)
	);

	// ======================================================================
	// Bus decode
	assign wb_acc = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
	assign wb_wr = wb_acc && wb_we_i;
	assign wr_mode = wb_wr && (wb_adr_i == `STW_OFS_MODE);
	assign wr_comm = wb_wr && (wb_adr_i == `STW_OFS_COMM);
	assign wr_data = wb_wr && (wb_adr_i == `STW_OFS_DATA);
	assign wr_olat = wb_wr && (wb_adr_i == `STW_OFS_OLAT);
	assign wr_oen = wb_wr && (wb_adr_i == `STW_OFS_OEN);
	assign wr_start = wb_wr && (wb_adr_i == `STW_OFS_START) &&
		wb_sel_i[0] && wb_dat_i[`STW_TRIG_CH];
	assign wr_stop = wb_wr && (wb_adr_i == `STW_OFS_STOP) &&
		wb_sel_i[0] && wb_dat_i[`STW_TRIG_CH];
	assign wr_clr = wb_wr && (wb_adr_i == `STW_OFS_CLR) && wb_sel_i[0];
	assign wr_prs = wb_wr && (wb_adr_i == `STW_OFS_PRS);
	assign rd_data = wb_acc && !wb_we_i && (wb_adr_i == `STW_OFS_DATA);

	// ======================================================================
	// Bus answer: one wait state, unmapped reads give zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (wb_adr_i)
			`STW_OFS_MODE: next_rdata[15:0] = channel_mode_reg;
			`STW_OFS_COMM: next_rdata[15:0] = channel_comm_setting_reg;
			`STW_OFS_DATA: next_rdata[15:0] =
				{divider, 1'b0, received_byte_field};
			`STW_OFS_OLAT: next_rdata[15:0] = serial_output_latch_reg;
			`STW_OFS_OEN: next_rdata[15:0] = serial_output_enable_reg;
			`STW_OFS_STAT: begin
				next_rdata[`STW_STAT_OVR] = overrun_flag;
				next_rdata[`STW_STAT_BFF] = buffer_full_flag;
				next_rdata[`STW_STAT_BUSY] = (state != STW_IDLE);
			end
			`STW_OFS_PRS: next_rdata[15:0] = prescaler_select_reg;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= next_rdata;
		end
	end

	// ======================================================================
	// Setup registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			channel_mode_reg <= `STW_RST_MODE;
			channel_comm_setting_reg <= `STW_RST_COMM;
			serial_output_latch_reg <= `STW_RST_OLAT;
			serial_output_enable_reg <= `STW_RST_OEN;
			prescaler_select_reg <= `STW_RST_PRS;
			divider <= DIV_W'(`STW_RST_DATA >> `STW_DIV_LSB);
		end else if (ce_i) begin
			if (wr_mode) begin
				channel_mode_reg <= merge(channel_mode_reg, wb_dat_i, wb_sel_i);
			end
			if (wr_comm) begin
				channel_comm_setting_reg <=
					merge(channel_comm_setting_reg, wb_dat_i, wb_sel_i);
			end
			if (wr_olat) begin
				serial_output_latch_reg <=
					merge(serial_output_latch_reg, wb_dat_i, wb_sel_i);
			end
			if (wr_oen) begin
				serial_output_enable_reg <=
					merge(serial_output_enable_reg, wb_dat_i, wb_sel_i);
			end
			if (wr_prs) begin
				prescaler_select_reg <=
					merge(prescaler_select_reg, wb_dat_i, wb_sel_i);
			end
			if (wr_data && wb_sel_i[1]) begin
				divider <= wb_dat_i[`STW_DIV_MSB:`STW_DIV_LSB];
			end
		end
	end

	// ======================================================================
	// Bit timing: each half period is divider+1 operation ticks
	assign half_done = (state != STW_IDLE) && op_tick && (ph_cnt == divider);
	assign byte_done = half_done && (state == STW_HIGH) &&
		(bit_cnt == `STW_BITS_PER_FRAME);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ph_cnt <= '0;
		end else if (ce_i) begin
			if (state == STW_IDLE || half_done) begin
				ph_cnt <= '0;
			end else if (op_tick) begin
				ph_cnt <= ph_cnt + 1'b1;
			end
		end
	end

	// ======================================================================
	// Frame sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= STW_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
		end else if (ce_i) begin
			if (wr_stop || !enabled) begin
				state <= STW_IDLE;
			end else begin
				case (state)
					STW_IDLE: begin
						if (wr_data) begin
							state <= STW_LOW;
							bit_cnt <= 4'h0;
						end
					end
					STW_LOW: begin
						if (half_done) begin
							state <= STW_HIGH;
						end
					end
					STW_HIGH: begin
						if (half_done) begin
							if (bit_cnt == `STW_BITS_PER_FRAME) begin
								state <= STW_IDLE;
							end else begin
								shift <= {shift[6:0], sda_s};
								bit_cnt <= bit_cnt + 4'h1;
								state <= STW_LOW;
							end
						end
					end
					default: state <= STW_IDLE;
				endcase
			end
		end
	end

	// ======================================================================
	// Channel enable and flags; the stop trigger beats any enable or buffer-full set, other sets beat a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enabled <= 1'b0;
		end else if (ce_i) begin
			if (wr_stop) begin
				enabled <= 1'b0;
			end else if (wr_start) begin
				enabled <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			buffer_full_flag <= 1'b0;
		end else if (ce_i) begin
			if (wr_stop) begin
				buffer_full_flag <= 1'b0;
			end else if (wr_start || byte_done) begin
				buffer_full_flag <= 1'b1;
			end else if (rd_data) begin
				buffer_full_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overrun_flag <= 1'b0;
		end else if (ce_i) begin
			if (byte_done && buffer_full_flag) begin
				overrun_flag <= 1'b1;
			end else if (wr_clr && wb_dat_i[`STW_STAT_OVR]) begin
				overrun_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			received_byte_field <= 8'h00;
			transfer_end_irq_o <= 1'b0;
		end else if (ce_i) begin
			transfer_end_irq_o <= byte_done;
			if (byte_done) begin
				received_byte_field <= shift;
			end
		end
	end

	// ======================================================================
	// Pin drive; outside frames software shapes start and stop
	always_comb begin
		next_scl_oe = !serial_output_latch_reg[`STW_OLAT_CLK];
		next_sda_oe = !serial_output_latch_reg[`STW_OLAT_DATA];
		if (state != STW_IDLE) begin
			next_scl_oe = (state == STW_LOW);
			next_sda_oe = 1'b0;
			if (bit_cnt == `STW_BITS_PER_FRAME) begin
				next_sda_oe = serial_output_enable_reg[`STW_OEN_CH];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			two_wire_clock_pin_oe_o <= 1'b0;
			two_wire_data_pin_oe_o <= 1'b0;
			two_wire_clock_pin_o <= 1'b0;
			two_wire_data_pin_o <= 1'b0;
		end else if (ce_i) begin
			two_wire_clock_pin_oe_o <= next_scl_oe;
			two_wire_data_pin_oe_o <= next_sda_oe;
			two_wire_clock_pin_o <= 1'b0;
			two_wire_data_pin_o <= 1'b0;
		end
	end

	// ======================================================================
	// Checks
	a_bff_read_clear: assert property (rd_data && !byte_done |=>
		!buffer_full_flag) else $error("buffer full not cleared by read");
	a_overrun_set: assert property (ce_i && byte_done && buffer_full_flag
		|=> overrun_flag) else $error("overrun missed on full buffer");
	a_stop_halts: assert property (wr_stop |=> !enabled &&
		!buffer_full_flag && state == STW_IDLE)
		else $error("stop trigger did not halt channel");
	a_start_fills: assert property (wr_start |=> enabled &&
		buffer_full_flag) else $error("start trigger did not enable channel");
	a_nack_release: assert property (ce_i && state != STW_IDLE &&
		bit_cnt == `STW_BITS_PER_FRAME &&
		!serial_output_enable_reg[`STW_OEN_CH] |=> !two_wire_data_pin_oe_o)
		else $error("data driven in NACK slot");
	a_data_no_drive: assert property (ce_i && state != STW_IDLE &&
		bit_cnt < `STW_BITS_PER_FRAME |=> !two_wire_data_pin_oe_o)
		else $error("data driven during slave bits");
	a_irq_single: assert property (ce_i && byte_done |=>
		transfer_end_irq_o ##1 !transfer_end_irq_o)
		else $error("transfer end pulse malformed");
	a_flag_clear: assert property (wr_clr && !wb_dat_i[`STW_STAT_OVR] &&
		overrun_flag |=> overrun_flag) else $error("unwritten flag was cleared");
	a_half_count: assert property (ce_i && state != STW_IDLE |->
		ph_cnt <= divider) else $error("half period overran divider");
	a_scl_low: assert property (ce_i && state == STW_LOW |=>
		two_wire_clock_pin_oe_o) else $error("clock not held low in low phase");

	c_byte: cover property (byte_done);
	c_overrun: cover property (byte_done && buffer_full_flag);
	c_nack: cover property (byte_done && !serial_output_enable_reg[`STW_OEN_CH]);
	c_stop: cover property (wr_stop && enabled);
endmodule
`default_nettype wire

/* File: test/stw_slave_model.sv */
// Purpose: Slave that returns one byte per frame on the data wire
// Assumes: Both wires pulled up; oe high pulls a wire low
// Notes: Releases the line in the ninth slot and records the answer
`timescale 1ns/1ns
`default_nettype none
module stw_slave_model (
	// Wires
	input wire logic scl_i,
	input wire logic sda_i,
	// Control
	input wire logic arm_i,
	input wire logic [7:0] byte_i,
	// Results
	output logic sda_oe_o,
	output logic ack_o
);
	int cnt = 0;
	logic [7:0] shreg = 8'hff;
	initial sda_oe_o = 1'b0;
	initial ack_o = 1'b1;
	// ==========================================================
	// Byte load
	always @(posedge arm_i) begin
		shreg = byte_i;
		cnt = 0;
	end
	// ==========================================================
	// Bit change only while the clock is low, held through high
	always @(negedge scl_i) begin
		sda_oe_o = (cnt < 8) ? ~shreg[7 - cnt] : 1'b0;
		cnt = cnt + 1;
	end
	always @(posedge scl_i) begin
		if (cnt == 9)
			ack_o = sda_i;
	end
endmodule
`default_nettype wire

/* File: test/test_stw_rx_channel.sv */
// Purpose: Self-checking bench for the two-wire receive channel
// Assumes: Pull-ups on both wires; divider of 2 or more
// Notes: Half periods judged on the second low half, after tick phase settles
`timescale 1ns/1ns
`default_nettype none
`include "stw_map.svh"
module test_stw_rx_channel;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [3:0] sel = 4'h0;
	logic tick = 1'b0;
	logic [1:0] tcnt = 2'h0;
	logic arm = 1'b0;
	logic [7:0] sbyte = 8'hff;
	logic [31:0] rdat;
	logic ack, scl_o, scl_oe, sda_o, sda_oe, irq, s_oe, s_ack;
	wire logic sda = ~(sda_oe | s_oe);
	wire logic scl = ~scl_oe;
	int failures = 0;
	int num_checks = 0;

	always #20 clk_i = ~clk_i;
	// Timer tick every fourth clock
	always @(posedge clk_i) begin
		tcnt <= tcnt + 2'h1;
		tick <= (tcnt == 2'h3);
	end

	stw_rx_channel stw_rx_channel_inst (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .timer_tick_i(tick), .two_wire_data_pin_i(sda),
		.two_wire_clock_pin_o(scl_o), .two_wire_clock_pin_oe_o(scl_oe),
		.two_wire_data_pin_o(sda_o), .two_wire_data_pin_oe_o(sda_oe),
		.transfer_end_irq_o(irq));
	stw_slave_model stw_slave_model_inst (.scl_i(scl), .sda_i(sda),
		.arm_i(arm), .byte_i(sbyte), .sda_oe_o(s_oe), .ack_o(s_ack));

	// ==========================================================
	// Shared tasks
	task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {16'h0000, d};
		sel <= 4'h3;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20)
			chk(16'h0, 16'h1, "no ack");
		q = rdat[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		wb(1'b1, a, d, q);
	endtask
	task rd(input logic [7:0] a, input logic [15:0] e, input string m);
		logic [15:0] q;
		wb(1'b0, a, 16'h0, q);
		chk(q, e, m);
	endtask
	task pins(input logic [1:0] e);
		repeat (2) @(posedge clk_i);
		chk({14'h0, scl_oe, sda_oe}, {14'h0, e}, "pins");
	endtask
	task wait_oe(input logic v);
		int n;
		n = 0;
		while (scl_oe !== v && n < 1000) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	// One received byte; ew is the expected low half width, 0 to skip
	task frame(input logic [7:0] b, input logic [15:0] d, input int ew);
		int n;
		sbyte <= b;
		arm <= 1'b1;
		@(posedge clk_i);
		arm <= 1'b0;
		wr(`STW_OFS_DATA, d);
		if (ew != 0) begin
			wait_oe(1'b1);
			wait_oe(1'b0);
			wait_oe(1'b1);
			n = 0;
			while (scl_oe === 1'b1 && n < 1000) begin
				@(posedge clk_i);
				n++;
			end
			chk(n[15:0], ew[15:0], "half width");
		end
		n = 0;
		while (irq !== 1'b1 && n < 9000) begin
			@(posedge clk_i);
			n++;
		end
		chk({15'h0, n < 9000}, 16'h1, "irq");
	endtask

	// ==========================================================
	// Scenarios
	task t_reset;
		rd(`STW_OFS_MODE, `STW_RST_MODE, "mode");
		rd(`STW_OFS_COMM, `STW_RST_COMM, "comm");
		rd(`STW_OFS_DATA, `STW_RST_DATA, "data");
		rd(`STW_OFS_OLAT, `STW_RST_OLAT, "olat");
		rd(`STW_OFS_OEN, `STW_RST_OEN, "oen");
		rd(`STW_OFS_PRS, `STW_RST_PRS, "prs");
		rd(`STW_OFS_STAT, 16'h0000, "stat");
		rd(8'h40, 16'h0000, "unmapped");
		pins(2'b00);
		chk({14'h0, scl_o, sda_o}, 16'h0000, "pin levels");
		$display("t_reset done");
	endtask
	task t_latch;
		wr(`STW_OFS_OLAT, 16'h0101);
		pins(2'b00);
		wr(`STW_OFS_OLAT, 16'h0100);
		pins(2'b01);
		wr(`STW_OFS_OLAT, 16'h0000);
		pins(2'b11);
		wr(`STW_OFS_OLAT, 16'h0100);
		pins(2'b01);
		wr(`STW_OFS_OLAT, 16'h0101);
		pins(2'b00);
		$display("t_latch done");
	endtask
	task t_rx;
		wr(`STW_OFS_DATA, 16'h06ff);
		wr(`STW_OFS_START, 16'h0001);
		rd(`STW_OFS_STAT, 16'h0020, "start full");
		rd(`STW_OFS_DATA, 16'h0600, "divider");
		rd(`STW_OFS_STAT, 16'h0000, "read clears");
		wr(`STW_OFS_OEN, 16'h0001);
		frame(8'ha5, 16'h06ff, 0);
		chk({15'h0, s_ack}, 16'h0, "ack");
		rd(`STW_OFS_STAT, 16'h0020, "full");
		rd(`STW_OFS_DATA, 16'h06a5, "byte");
		rd(`STW_OFS_STAT, 16'h0000, "cleared");
		$display("t_rx done");
	endtask
	task t_ovr;
		frame(8'h5a, 16'h06ff, 0);
		wr(`STW_OFS_OEN, 16'h0000);
		frame(8'h3c, 16'h06ff, 0);
		chk({15'h0, s_ack}, 16'h1, "nack");
		rd(`STW_OFS_STAT, 16'h0021, "overrun");
		rd(`STW_OFS_DATA, 16'h063c, "last byte");
		wr(`STW_OFS_CLR, 16'h0020);
		rd(`STW_OFS_STAT, 16'h0001, "flag kept");
		wr(`STW_OFS_CLR, 16'h0021);
		rd(`STW_OFS_STAT, 16'h0000, "flag clear");
		$display("t_ovr done");
	endtask
	task t_stop;
		int n;
		wr(`STW_OFS_START, 16'h0001);
		wr(`STW_OFS_DATA, 16'h06ff);
		wait_oe(1'b1);
		wr(`STW_OFS_STOP, 16'h0001);
		rd(`STW_OFS_STAT, 16'h0000, "stopped");
		n = 0;
		repeat (300) begin
			@(posedge clk_i);
			if (irq === 1'b1)
				n++;
		end
		chk(n[15:0], 16'h0, "no irq");
		pins(2'b00);
		wr(`STW_OFS_START, 16'h0001);
		rd(`STW_OFS_STAT, 16'h0020, "restart");
		$display("t_stop done");
	endtask
	task t_rate;
		logic [15:0] prs [5] = '{16'h0000, 16'h0002, 16'h0007, 16'h0010,
			16'h00f0};
		logic [15:0] mode [5] = '{16'h0020, 16'h0020, 16'h0020, 16'h8020,
			16'h8020};
		int ew [5] = '{3, 12, 384, 6, 12};
		for (int i = 0; i < 5; i++) begin
			wr(`STW_OFS_STOP, 16'h0001);
			wr(`STW_OFS_PRS, prs[i]);
			wr(`STW_OFS_MODE, mode[i]);
			wr(`STW_OFS_START, 16'h0001);
			frame(8'hff, 16'h04ff, ew[i]);
		end
		$display("t_rate done");
	endtask

	// Clock enable low mid-frame: clock stays pulled, frame resumes after
	task t_freeze;
		int n;
		sbyte <= 8'h81;
		arm <= 1'b1;
		@(posedge clk_i);
		arm <= 1'b0;
		wr(`STW_OFS_DATA, 16'h04ff);
		wait_oe(1'b1);
		ce <= 1'b0;
		repeat (41) @(posedge clk_i);
		chk({15'h0, scl_oe}, 16'h0001, "frozen low");
		chk({15'h0, irq}, 16'h0000, "no irq frozen");
		ce <= 1'b1;
		n = 0;
		while (irq !== 1'b1 && n < 9000) begin
			@(posedge clk_i);
			n++;
		end
		chk({15'h0, n < 9000}, 16'h1, "irq after freeze");
		rd(`STW_OFS_DATA, 16'h0481, "byte after freeze");
		$display("t_freeze done");
	endtask

	task end_sim;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_latch();
		t_rx();
		t_ovr();
		t_stop();
		t_rate();
		t_freeze();
		end_sim();
	end
	initial begin
		#1600000;
		failures++;
		end_sim();
	end
endmodule
`default_nettype wire
